// ===== design/amp_control_port.sv
// Behaviour
// [R01] state code 00 is deep sleep; play not reachable directly from it
// [R02] state code 01 is sleep; core sleeps, analog supply stays on, code 11 resumes play
// [R03] state code 10 only floats the output driver; code 11 resumes play
// [R04] state code 11 is play with the output stage switching
// [R05] host leaves deep sleep via page/book select, hi-z, then play
// [R06] register 0x02 low two bits pick one of three modulation schemes
// [R07] both-side: outputs in phase at zero, duty split around half
// [R08] single-side: idle near 14 percent, falling side rails to ground
// [R09] hybrid: duty adapts to signal level and programmed supply value
// [R10] host uses both/single side, hi-z, 2ms, hybrid, 15ms, then play
// [R11] bus slave for standard and fast rate, random and sequential
// [R12] register 0 on every page selects the page, 0 to 255
// [R13] slave address is 01011 followed by two strap bits
// [R14] strap decodes 4.7k to 00, 15k to 01, 47k to 10, 120k to 11
// [R15] write: address with write bit, register, data, all acknowledged
// [R16] sequential write acknowledges each byte and bumps the subaddress
// [R17] read: register write, repeated start, address with read bit
// [R18] sequential read returns consecutive bytes, master nacks the last
// [R19] register 0x7f on page 0 selects the book
// [R20] unimplemented addresses read zero, writes acked and dropped
`include "amp_ctrl_cfg.svh"

module amp_control_port
   import amp_ctrl_pkg::*;
#(
   parameter int LEVEL_WIDTH = 8
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // serial control bus, open drain data
   input  wire logic                          scl_in,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe,
   // address strap comparators, thermometer coded
   input  wire logic [2:0]                    strap_sense,
   // audio level feeding the modulator
   input  wire logic signed [LEVEL_WIDTH-1:0] audio_level,
   // amplifier side
   output pwm_pair_t                          amp_outputs,
   output power_t                             power_status,
   output logic [1:0]                         amp_modulation_select,
   output logic [1:0]                         device_state
);

   typedef struct packed {
      // synchronisers, previous samples and strap capture
      logic       scl_m;
      logic       scl_s;
      logic       scl_p;
      logic       sda_m;
      logic       sda_s;
      logic       sda_p;
      logic [2:0] strap_m;
      logic [2:0] strap_s;
      logic [1:0] strap_cnt;
      logic       strap_done;
      logic [1:0] strap_bits;
      // serial engine
      phase_t     ph;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic       rw;
      logic       got_sub;
      logic       master_ack;
      logic [7:0] sub;
      logic       sda_oe;
      // register file
      logic [7:0] page;
      logic [7:0] book;
      logic [7:0] mod_reg;
      logic [7:0] state_reg;
      logic [7:0] supply_reg;
      power_t     pwr;
   } ctl_state_t;

   ctl_state_t st_q;
   ctl_state_t st_d;

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic main_regs;

   assign scl_rise  = st_q.scl_s && !st_q.scl_p;
   assign scl_fall  = !st_q.scl_s && st_q.scl_p;
   assign bus_start = st_q.scl_s && st_q.scl_p &&
                      st_q.sda_p && !st_q.sda_s;
   assign bus_stop  = st_q.scl_s && st_q.scl_p &&
                      !st_q.sda_p && st_q.sda_s;
   // control registers live on book 0, page 0 only
   assign main_regs = (st_q.book == 8'h00) && (st_q.page == 8'h00);

   // read mux
   function automatic logic [7:0] rd_byte(
      input logic [7:0] addr,
      input logic [7:0] page,
      input logic [7:0] book,
      input logic [7:0] mod_reg,
      input logic [7:0] state_reg,
      input logic [7:0] supply_reg
   );
      logic main;
      main = (book == 8'h00) && (page == 8'h00);
      rd_byte = 8'h00; // R20
      if (addr == `REG_PAGE_SELECT) begin
         rd_byte = page; // R12
      end else if (addr == `REG_BOOK_SELECT && page == 8'h00) begin
         rd_byte = book; // R19
      end else if (main) begin
         case (addr)
            `REG_MODULATION_CONTROL:   rd_byte = mod_reg;
            `REG_DEVICE_STATE_CONTROL: rd_byte = state_reg;
            `REG_SUPPLY_LEVEL:         rd_byte = supply_reg;
            default:                   rd_byte = 8'h00; // R20
         endcase
      end
   endfunction : rd_byte

   always_comb begin
      logic [6:0] own_addr;
      logic [7:0] wr_val;
      logic [1:0] cur_state;
      logic [1:0] new_state;
      st_d = st_q;
      own_addr = {`SLAVE_ADDR_FIXED, st_q.strap_bits}; // R13
      wr_val = st_q.shreg;
      cur_state = st_q.state_reg[`FIELD_MSB:`FIELD_LSB];
      new_state = wr_val[`FIELD_MSB:`FIELD_LSB];

      // two flip-flops ahead of any pin reader
      st_d.scl_m   = scl_in;
      st_d.scl_s   = st_q.scl_m;
      st_d.scl_p   = st_q.scl_s;
      st_d.sda_m   = sda_in;
      st_d.sda_s   = st_q.sda_m;
      st_d.sda_p   = st_q.sda_s;
      st_d.strap_m = strap_sense;
      st_d.strap_s = st_q.strap_m;

      // strap caught once, after settling
      if (!st_q.strap_done) begin
         if (st_q.strap_cnt == `STRAP_SETTLE) begin
            st_d.strap_done = 1'b1;
            case (st_q.strap_s)
               3'h0:    st_d.strap_bits = 2'h0; // R14
               3'h1:    st_d.strap_bits = 2'h1; // R14
               3'h3:    st_d.strap_bits = 2'h2; // R14
               3'h7:    st_d.strap_bits = 2'h3; // R14
               default: st_d.strap_bits = 2'h0;
            endcase
         end else begin
            st_d.strap_cnt = st_q.strap_cnt + 2'h1;
         end
      end

      if (bus_stop) begin
         st_d.ph     = PH_IDLE;
         st_d.sda_oe = 1'b0;
      end else if (bus_start) begin
         // repeated start keeps the subaddress
         st_d.ph      = PH_ADDR; // R17
         st_d.bit_cnt = 4'h0;
         st_d.sda_oe  = 1'b0;
      end else begin
         case (st_q.ph) // R11
            PH_IDLE: begin
            end
            PH_ADDR: begin
               if (scl_rise) begin
                  st_d.shreg   = {st_q.shreg[6:0], st_q.sda_s};
                  st_d.bit_cnt = st_q.bit_cnt + 4'h1;
               end else if (scl_fall && st_q.bit_cnt == 4'h8) begin
                  st_d.bit_cnt = 4'h0;
                  if (st_q.shreg[7:1] == own_addr) begin // R13
                     st_d.rw     = st_q.shreg[0];
                     st_d.sda_oe = 1'b1; // R15
                     st_d.ph     = PH_ADDR_ACK;
                  end else begin
                     st_d.ph = PH_WAIT;
                  end
               end
            end
            PH_ADDR_ACK: begin
               if (scl_fall) begin
                  st_d.bit_cnt = 4'h0;
                  if (st_q.rw) begin
                     st_d.shreg = rd_byte(st_q.sub, st_q.page, st_q.book,
                                          st_q.mod_reg, st_q.state_reg,
                                          st_q.supply_reg); // R17
                     st_d.sda_oe = !st_d.shreg[7];
                     st_d.ph     = PH_TX;
                  end else begin
                     st_d.sda_oe  = 1'b0;
                     st_d.got_sub = 1'b0;
                     st_d.ph      = PH_RX;
                  end
               end
            end
            PH_RX: begin
               if (scl_rise) begin
                  st_d.shreg   = {st_q.shreg[6:0], st_q.sda_s};
                  st_d.bit_cnt = st_q.bit_cnt + 4'h1;
               end else if (scl_fall && st_q.bit_cnt == 4'h8) begin
                  st_d.bit_cnt = 4'h0;
                  st_d.sda_oe  = 1'b1; // R15
                  st_d.ph      = PH_RX_ACK;
                  if (!st_q.got_sub) begin
                     st_d.sub     = wr_val; // R15
                     st_d.got_sub = 1'b1;
                  end else begin
                     st_d.sub = st_q.sub + 8'h01; // R16
                     if (st_q.sub == `REG_PAGE_SELECT) begin
                        st_d.page = wr_val; // R12
                     end else if (st_q.sub == `REG_BOOK_SELECT &&
                                  st_q.page == 8'h00) begin
                        st_d.book = wr_val; // R19
                     end else if (main_regs) begin
                        case (st_q.sub)
                           `REG_MODULATION_CONTROL: begin
                              st_d.mod_reg = wr_val; // R06
                           end
                           `REG_DEVICE_STATE_CONTROL: begin
                              // no direct jump from deep sleep to play
                              if (!(cur_state == `ST_DEEP_SLEEP &&
                                    new_state == `ST_PLAY)) begin
                                 st_d.state_reg = wr_val; // R01
                              end
                           end
                           `REG_SUPPLY_LEVEL: begin
                              st_d.supply_reg = wr_val; // R09
                           end
                           default: begin
                           end // R20
                        endcase
                     end
                  end
               end
            end
            PH_RX_ACK: begin
               if (scl_fall) begin
                  st_d.sda_oe = 1'b0;
                  st_d.ph     = PH_RX;
               end
            end
            PH_TX: begin
               if (scl_rise) begin
                  st_d.bit_cnt = st_q.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (st_q.bit_cnt == 4'h8) begin
                     st_d.sda_oe = 1'b0;
                     st_d.ph     = PH_TX_ACK;
                  end else begin
                     st_d.shreg  = {st_q.shreg[6:0], 1'b0};
                     st_d.sda_oe = !st_q.shreg[6];
                  end
               end
            end
            PH_TX_ACK: begin
               if (scl_rise) begin
                  st_d.master_ack = !st_q.sda_s;
                  st_d.sub        = st_q.sub + 8'h01; // R18
               end else if (scl_fall) begin
                  st_d.bit_cnt = 4'h0;
                  if (st_q.master_ack) begin
                     st_d.shreg = rd_byte(st_q.sub, st_q.page, st_q.book,
                                          st_q.mod_reg, st_q.state_reg,
                                          st_q.supply_reg); // R18
                     st_d.sda_oe = !st_d.shreg[7];
                     st_d.ph     = PH_TX;
                  end else begin
                     // nack: wait for stop
                     st_d.ph = PH_WAIT; // R18
                  end
               end
            end
            PH_WAIT: begin
            end
            default: begin
               st_d.ph     = PH_IDLE;
               st_d.sda_oe = 1'b0;
            end
         endcase
      end

      // power controls follow the state field
      case (st_d.state_reg[`FIELD_MSB:`FIELD_LSB])
         `ST_DEEP_SLEEP: begin
            st_d.pwr = '{analog_ldo_en: 1'b0, core_sleep: 1'b1,
                         driver_enable: 1'b0}; // R01
         end
         `ST_SLEEP: begin
            st_d.pwr = '{analog_ldo_en: 1'b1, core_sleep: 1'b1,
                         driver_enable: 1'b0}; // R02
         end
         `ST_HIZ: begin
            st_d.pwr = '{analog_ldo_en: 1'b1, core_sleep: 1'b0,
                         driver_enable: 1'b0}; // R03
         end
         default: begin
            st_d.pwr = '{analog_ldo_en: 1'b1, core_sleep: 1'b0,
                         driver_enable: 1'b1}; // R04
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q            <= '0;
         st_q.scl_m      <= 1'b1;
         st_q.scl_s      <= 1'b1;
         st_q.scl_p      <= 1'b1;
         st_q.sda_m      <= 1'b1;
         st_q.sda_s      <= 1'b1;
         st_q.sda_p      <= 1'b1;
         st_q.ph         <= PH_IDLE;
         st_q.page       <= `RST_PAGE;
         st_q.book       <= `RST_BOOK;
         st_q.mod_reg    <= `RST_MOD;
         st_q.state_reg  <= `RST_STATE;
         st_q.supply_reg <= `RST_SUPPLY;
         st_q.pwr        <= '{analog_ldo_en: 1'b1, core_sleep: 1'b0,
                              driver_enable: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // modulator only switches in play
   amp_pwm_modulator #(
      .WIDTH(LEVEL_WIDTH)
   ) u_pwm (
      .clk         (clk),
      .rst_n       (rst_n),
      .enable      (st_q.pwr.driver_enable), // R04
      .scheme      (st_q.mod_reg[`FIELD_MSB:`FIELD_LSB]), // R06
      .supply_level(st_q.supply_reg),
      .level       (audio_level),
      .outputs     (amp_outputs)
   );

   // open drain
   assign sda_out               = 1'b0;
   assign sda_oe                = st_q.sda_oe;
   assign power_status          = st_q.pwr;
   assign amp_modulation_select = st_q.mod_reg[`FIELD_MSB:`FIELD_LSB];
   assign device_state          = st_q.state_reg[`FIELD_MSB:`FIELD_LSB];

endmodule : amp_control_port

// ===== design/amp_ctrl_cfg.svh
`ifndef AMP_CTRL_CFG_SVH
`define AMP_CTRL_CFG_SVH

// register offsets
`define REG_PAGE_SELECT          8'h00
`define REG_MODULATION_CONTROL   8'h02
`define REG_DEVICE_STATE_CONTROL 8'h03
`define REG_SUPPLY_LEVEL         8'h04
`define REG_BOOK_SELECT          8'h7f

// field position of the two-bit mode fields
`define FIELD_MSB 1
`define FIELD_LSB 0

// reset values
`define RST_PAGE   8'h00
`define RST_BOOK   8'h00
`define RST_MOD    8'h00
`define RST_STATE  8'h02
`define RST_SUPPLY 8'h80

// state field codes
`define ST_DEEP_SLEEP 2'h0
`define ST_SLEEP      2'h1
`define ST_HIZ        2'h2
`define ST_PLAY       2'h3

// modulation field codes
`define MOD_BOTH_SIDE   2'h0
`define MOD_SINGLE_SIDE 2'h1
`define MOD_HYBRID      2'h2

// slave address: fixed upper bits, strap gives the two low bits
`define SLAVE_ADDR_FIXED 5'h0b

// pwm duties on a 256-step carrier; idle of 36/256 is about 14 percent
`define DUTY_HALF 9'h080
`define DUTY_IDLE 9'h024
`define DUTY_MAX  9'h0ff

// timing counts
`define PWM_TICK_DIV 4'h3
`define STRAP_SETTLE 2'h3

`endif

// ===== design/amp_ctrl_pkg.sv
package amp_ctrl_pkg;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_ADDR_ACK,
      PH_RX,
      PH_RX_ACK,
      PH_TX,
      PH_TX_ACK,
      PH_WAIT
   } phase_t;

   typedef struct packed {
      logic positive_output;
      logic negative_output;
   } pwm_pair_t;

   typedef struct packed {
      logic analog_ldo_en;
      logic core_sleep;
      logic driver_enable;
   } power_t;

endpackage : amp_ctrl_pkg

// ===== design/amp_pwm_modulator.sv
`include "amp_ctrl_cfg.svh"

module amp_pwm_modulator
   import amp_ctrl_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // control
   input  wire logic                    enable,
   input  wire logic [1:0]              scheme,
   input  wire logic [7:0]              supply_level,
   input  wire logic signed [WIDTH-1:0] level,
   // output pair
   output pwm_pair_t                    outputs
);

   typedef struct packed {
      logic [3:0] div_cnt;
      logic [7:0] carrier;
      pwm_pair_t  pair;
   } pwm_state_t;

   pwm_state_t st_q;
   pwm_state_t st_d;

   always_comb begin
      logic signed [8:0] lvl;
      logic [8:0]        mag;
      logic [8:0]        rising;
      logic [8:0]        falling;
      logic [8:0]        pos_duty;
      logic [8:0]        neg_duty;
      logic              use_single;
      pos_duty = 9'h000;
      neg_duty = 9'h000;
      st_d = st_q;
      lvl = 9'(level);
      if (lvl < -9'sd127) begin
         lvl = -9'sd127;
      end
      mag = lvl[8] ? 9'(-lvl) : 9'(lvl);
      // falling side rails to ground
      rising = `DUTY_IDLE + mag; // R08
      if (rising > `DUTY_MAX) begin
         rising = `DUTY_MAX;
      end
      falling = (mag >= `DUTY_IDLE) ? 9'h000 : `DUTY_IDLE - mag; // R08
      // hybrid: small signals run single-sided
      use_single = (scheme == `MOD_SINGLE_SIDE) ||
                   ((scheme == `MOD_HYBRID) &&
                    (mag < {3'h0, supply_level[7:2]})); // R09
      if (use_single) begin
         pos_duty = lvl[8] ? falling : rising;
         neg_duty = lvl[8] ? rising : falling;
      end else begin
         // in phase at zero input
         pos_duty = 9'(`DUTY_HALF + lvl); // R07
         neg_duty = 9'(`DUTY_HALF - lvl); // R07
      end
      if (st_q.div_cnt == 4'h0) begin
         st_d.div_cnt = `PWM_TICK_DIV;
         st_d.carrier = st_q.carrier + 8'h01;
      end else begin
         st_d.div_cnt = st_q.div_cnt - 4'h1;
      end
      st_d.pair.positive_output = enable &&
                                  ({1'b0, st_q.carrier} < pos_duty);
      st_d.pair.negative_output = enable &&
                                  ({1'b0, st_q.carrier} < neg_duty);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign outputs = st_q.pair;

endmodule : amp_pwm_modulator

// ===== testbench/amp_control_port_state_modulation_tb.sv
`define CHK(nm, e, s) \
   begin \
      checks++; \
      if ((s) !== (e)) begin \
         bad_count++; \
         $display("BAD %s exp %0h got %0h", nm, e, s); \
      end \
   end

module amp_control_port_state_modulation_tb
   import amp_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 90000;

   logic              clk;
   logic              rst_n;
   logic              scl;
   logic              sda;
   logic              sda_oe;
   logic [2:0]        strap_sense;
   logic signed [7:0] audio_level;
   pwm_pair_t         amp_outputs;
   power_t            power_status;
   logic [1:0]        amp_modulation_select;
   logic [1:0]        device_state;
   logic [6:0]        dev_addr;
   logic [7:0]        page_m, book_m, mod_m, st_m, sup_m;
   int                bad_count;
   int                checks;
   int                cycles;
   logic [2:0]        straps [4] = '{3'b000, 3'b001, 3'b011, 3'b111};
   logic [7:0]        subs [5] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h7f};
   logic [15:0]       seq [14] = '{16'h0302, 16'h0303, 16'h0301,
      16'h0303, 16'h0300, 16'h0303, 16'h0000, 16'h7f00, 16'h0302,
      16'h0300, 16'h0000, 16'h7f00, 16'h0302, 16'h0303};

   amp_control_port #(.LEVEL_WIDTH(8)) uut (
      .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .strap_sense(strap_sense),
      .audio_level(audio_level), .amp_outputs(amp_outputs),
      .power_status(power_status),
      .amp_modulation_select(amp_modulation_select),
      .device_state(device_state));

   amp_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   always #5 clk = !clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         results();
      end
   end

   task automatic results();
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   function automatic void mdl_wr(logic [7:0] a, d);
      if (a == 8'h00)
         page_m = d;
      else if (a == 8'h7f && page_m == 8'h00)
         book_m = d;
      else if (page_m == 8'h00 && book_m == 8'h00) begin
         if (a == 8'h02)
            mod_m = d;
         else if (a == 8'h03 && !(st_m[1:0] == 2'h0 && d[1:0] == 2'h3))
            st_m = d;
         else if (a == 8'h04)
            sup_m = d;
      end
   endfunction : mdl_wr

   function automatic logic [7:0] mdl_rd(logic [7:0] a);
      if (a == 8'h00)
         return page_m;
      if (a == 8'h7f)
         return (page_m == 8'h00) ? book_m : 8'h00;
      if (page_m != 8'h00 || book_m != 8'h00)
         return 8'h00;
      case (a)
         8'h02: return mod_m;
         8'h03: return st_m;
         8'h04: return sup_m;
         default: return 8'h00;
      endcase
   endfunction : mdl_rd

   task automatic do_reset(logic [2:0] s);
      rst_n       <= 1'b0;
      strap_sense <= s;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      page_m = 8'h00;
      book_m = 8'h00;
      mod_m  = 8'h00;
      st_m   = 8'h02;
      sup_m  = 8'h80;
   endtask : do_reset

   task automatic head(logic [7:0] sub);
      logic ack;
      host.start();
      host.send({dev_addr, 1'b0}, ack);
      `CHK("addr ack", 1'b1, ack)
      host.send(sub, ack);
      `CHK("sub ack", 1'b1, ack)
   endtask : head

   task automatic wr(logic [7:0] sub, logic [7:0] q[$]);
      logic       ack;
      logic [7:0] a;
      a = sub;
      head(sub);
      foreach (q[i]) begin
         host.send(q[i], ack);
         `CHK("data ack", 1'b1, ack)
         mdl_wr(a, q[i]);
         a++;
      end
      host.stop();
      repeat (8) @(posedge clk);
      `CHK("device_state", st_m[1:0], device_state)
      `CHK("modulation", mod_m[1:0], amp_modulation_select)
   endtask : wr

   task automatic rd(logic [7:0] sub, int n);
      logic       ack;
      logic [7:0] d, a;
      a = sub;
      head(sub);
      host.start();
      host.send({dev_addr, 1'b1}, ack);
      `CHK("read addr ack", 1'b1, ack)
      for (int i = 0; i < n; i++) begin
         host.recv(i == n - 1, d);
         `CHK("read data", mdl_rd(a), d)
         a++;
      end
      host.stop();
   endtask : rd

   task automatic duty(int lvl, ep, en);
      int p;
      int n;
      audio_level <= 8'(lvl);
      repeat (512) @(posedge clk);
      repeat (1024) begin
         @(negedge clk);
         p += int'(amp_outputs.positive_output);
         n += int'(amp_outputs.negative_output);
      end
      `CHK("pos duty", 1'b1, p <= ep * 4 + 8 && p >= ep * 4 - 8)
      `CHK("neg duty", 1'b1, n <= en * 4 + 8 && n >= en * 4 - 8)
   endtask : duty

   initial begin
      logic ack;
      clk         = 1'b0;
      rst_n       = 1'b0;
      strap_sense = 3'b000;
      audio_level = 8'sh00;
      void'($urandom(32'hcca792e2));
      for (int i = 0; i < 4; i++) begin
         do_reset(straps[i]);
         dev_addr = {5'h0b, 2'(i)};
         host.start();
         host.send({dev_addr ^ (i[0] ? 7'h01 : 7'h40), 1'b0}, ack);
         `CHK("foreign addr ack", 1'b0, ack)
         host.stop();
         rd(8'h00, 5);
      end
      wr(8'h02, '{8'h01, 8'h01, 8'h90});
      foreach (seq[i])
         wr(seq[i][15:8], '{seq[i][7:0]});
      wr(8'h02, '{8'h00});
      duty(0, 128, 128);
      duty(40, 168, 88);
      wr(8'h02, '{8'h01});
      duty(0, 36, 36);
      audio_level <= 8'sh64;
      repeat (200) @(posedge clk);
      wr(8'h03, '{8'h00});
      wr(8'h02, '{8'h00});
      wr(8'h03, '{8'h02});
      repeat (200) @(posedge clk);
      wr(8'h02, '{8'h02});
      repeat (300) @(posedge clk);
      wr(8'h03, '{8'h03});
      duty(0, 36, 36);
      wr(8'h00, '{8'h05});
      wr(8'h02, '{8'h03});
      wr(8'h7f, '{8'h8c});
      rd(8'h00, 3);
      wr(8'h00, '{8'h00});
      wr(8'h7f, '{8'h8c});
      rd(8'h7e, 6);
      wr(8'h7f, '{8'h00});
      wr(8'h10, '{8'($urandom)});
      rd(8'hfe, 6);
      for (int i = 0; i < 8; i++) begin
         audio_level <= 8'($urandom);
         wr(subs[$urandom % 5], '{8'($urandom)});
         rd(subs[$urandom % 5], 2);
      end
      results();
   end
endmodule : amp_control_port_state_modulation_tb

bind amp_control_port amp_control_port_sva #(.LEVEL_WIDTH(LEVEL_WIDTH)) sva (
   .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .strap_sense(strap_sense),
   .audio_level(audio_level), .amp_outputs(amp_outputs),
   .power_status(power_status),
   .amp_modulation_select(amp_modulation_select),
   .device_state(device_state));

// ===== testbench/amp_control_port_sva.sv
module amp_control_port_sva
   import amp_ctrl_pkg::*;
#(
   parameter int LEVEL_WIDTH = 8
) (
   // clock and reset
   input wire logic                          clk,
   input wire logic                          rst_n,
   // serial bus
   input wire logic                          scl_in,
   input wire logic                          sda_in,
   input wire logic                          sda_out,
   input wire logic                          sda_oe,
   // strap and audio
   input wire logic [2:0]                    strap_sense,
   input wire logic signed [LEVEL_WIDTH-1:0] audio_level,
   // amplifier side
   input pwm_pair_t                          amp_outputs,
   input power_t                             power_status,
   input wire logic [1:0]                    amp_modulation_select,
   input wire logic [1:0]                    device_state
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   AST_ACK_ON_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("sda_oe rose while scl high");
   AST_SDA_HOLD: assert property (
      scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("sda_oe moved while scl high");
   AST_RESET_VALUES: assert property ($rose(rst_n) |-> device_state == 2'h2
      && amp_modulation_select == 2'h0 && power_status == 3'b100)
      else $error("wrong values after reset");
   AST_REG_ON_SCL_LOW: assert property (
      !$stable({device_state, amp_modulation_select}) |-> !scl_in)
      else $error("register changed while scl high");
   AST_DEEP_SLEEP_HOLD: assert property (
      $past(device_state) == 2'h0 |-> device_state != 2'h3)
      else $error("deep sleep to play");
   AST_DEEP_SLEEP_POWER: assert property (device_state == 2'h0 [*2] |->
      !power_status.analog_ldo_en && !power_status.driver_enable)
      else $error("deep sleep power wrong");
   AST_SLEEP_POWER: assert property (device_state == 2'h1 [*2] |->
      power_status.analog_ldo_en && !power_status.driver_enable
      && power_status.core_sleep)
      else $error("sleep power wrong");
   AST_HIZ_POWER: assert property (device_state == 2'h2 [*2] |->
      power_status.analog_ldo_en && !power_status.driver_enable
      && !power_status.core_sleep)
      else $error("hi-z power wrong");
   AST_PLAY_POWER: assert property (device_state == 2'h3 [*2] |->
      power_status.analog_ldo_en && power_status.driver_enable
      && !power_status.core_sleep)
      else $error("play power wrong");
   AST_OUTPUTS_QUIET: assert property (
      device_state != 2'h3 [*8] |-> amp_outputs == 2'b00)
      else $error("outputs switching outside play");
   AST_BD_IN_PHASE: assert property ((device_state == 2'h3
      && amp_modulation_select == 2'h0 && audio_level == 0) [*8]
      |-> amp_outputs.positive_output == amp_outputs.negative_output)
      else $error("both-side not in phase");
   AST_SINGLE_SIDE_RAIL: assert property ((device_state == 2'h3
      && amp_modulation_select == 2'h1 && audio_level > 64) [*8]
      |-> !amp_outputs.negative_output)
      else $error("falling output high");
endmodule : amp_control_port_sva

// ===== testbench/amp_host_model.sv
module amp_host_model (
   // clock
   input  wire logic clk,
   // bus pins, sda pulled up
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int STEP = 10;

   logic drv_low;

   initial begin
      scl     = 1'b1;
      drv_low = 1'b0;
   end

   // released line floats up through the pull-up
   assign sda = !(drv_low || sda_oe);

   task automatic pin(logic s, d);
      scl     <= s;
      drv_low <= !d;
      repeat (STEP) @(posedge clk);
   endtask : pin

   task automatic bit_io(logic b, output logic r);
      pin(1'b0, b);
      pin(1'b1, b);
      r = sda;
      pin(1'b0, b);
   endtask : bit_io

   task automatic start();
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
      pin(1'b0, 1'b0);
   endtask : start

   task automatic stop();
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
      pin(1'b1, 1'b1);
   endtask : stop

   task automatic send(logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : send

   task automatic recv(logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask : recv
endmodule : amp_host_model
